/* File: src/accel_pkg.sv */
/*
 * Shared constants and carriers of the accelerometer output and mode block.
 * Assumes a 32-bit Avalon-MM register bus and a sampling front end on its own clock.
 */
package accel_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int RAW_W = 16;
    localparam int DATA_W = 12;
    localparam int SUM_W = 26;
    localparam int NVM_WORDS = 6;
    localparam int OUT_REGS = 6;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] OUT_BASE_OFS = 8'h04;
    localparam logic [7:0] CTRL_OFS = 8'h1c;
    localparam logic [7:0] CFG_OFS = 8'h20;
    localparam logic [7:0] UOFF_BASE_OFS = 8'h24;
    localparam logic [7:0] BURST_OFS = 8'h3c;
    localparam logic [7:0] PTR_OFS = 8'h40;

    // ------------------------------------------------------------
    // Fields, codes and reset values
    // ------------------------------------------------------------
    localparam int CTRL_ACTIVE_BIT = 0;
    localparam int CTRL_FREAD_BIT = 1;
    localparam int CFG_ST_BIT = 2;
    localparam int STATUS_MODE_LSB = 1;
    localparam logic [1:0] RANGE_2G = 2'h0;
    localparam logic [1:0] RANGE_4G = 2'h1;
    localparam logic [1:0] RANGE_8G = 2'h2;
    localparam int BASE_SHIFT = 2;
    localparam int GAIN_SHIFT = 8;
    localparam logic signed [9:0] GAIN_UNITY = 10'sh100;
    localparam logic [1:0] SYSMODE_STANDBY = 2'h0;
    localparam logic [1:0] SYSMODE_WAKE = 2'h1;
    localparam logic [1:0] SYSMODE_SLEEP = 2'h2;
    localparam logic [2:0] PTR_RESET = 3'h0;
    localparam logic [2:0] PTR_LAST = 3'h5;
    localparam logic [2:0] PTR_LAST_MSB = 3'h4;
    localparam logic [2:0] FAC_OFF_IDX = 3'h3;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic signed [RAW_W-1:0] x;
        logic signed [RAW_W-1:0] y;
        logic signed [RAW_W-1:0] z;
    } axis_raw_t;

    typedef struct packed {
        logic [DATA_W-1:0] x;
        logic [DATA_W-1:0] y;
        logic [DATA_W-1:0] z;
    } axis_out_t;

    typedef enum logic [3:0] {
        MODE_LOAD = 4'b0001,
        MODE_STANDBY = 4'b0010,
        MODE_WAKE = 4'b0100,
        MODE_SLEEP = 4'b1000
    } mode_t;

endpackage

/* File: src/accel_readout.sv */
/*
 * Output data path and operating mode control of a three-axis accelerometer:
 * trim load, offset and self-test summing, range scaling, registers and modes.
 * Assumes a raw sample stream at 4096 counts per g on its own free-running
 * sampling clock, a trim store answering one cycle after its read strobe, and
 * an Avalon-MM master on ref_clk.
 */
// Design decisions made here: the register addresses and register access over Avalon-MM.
// How it works
// - Counts per g 1024, 512, 256 by range.
// - Samples are signed two's complement codes.
// - Standby keeps logic only, sampling stopped.
// - Active bit enables sampling and analog blocks.
// - Leaving active keeps every register value.
// - Entering active clears output data registers.
// - Sleep and wake are both active substates.
// - Twelve-bit sample split over two bytes.
// - Upper byte holds eight most significant bits.
// - Fast read only while its bit is set.
// - Two-g range spans -2 to 1.999 g.
// - Eight-g range spans -8 to 7.996 g.
// - Upper byte alone is sixteen times coarser.
// - Factory trim loads before any measurement.
// - Six writable volatile user offset registers.
// - Self-test adds stimulus to real acceleration.
// - Every function works in every range.
module accel_readout #(
    parameter logic signed [15:0] ST_RAW = 16'sh0400
) (
    // System clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Avalon-MM register slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Sampling front end
    input wire logic sense_clk,
    input wire accel_pkg::axis_raw_t raw_sample,
    input wire logic raw_valid,
    output logic sampling_en,
    output logic analog_en,
    // Trim store
    output logic nvm_rd,
    output logic [2:0] nvm_addr,
    input wire logic [15:0] nvm_data,
    // Auto-sleep request from the motion engines
    input wire logic sleep_req
);
    import accel_pkg::*;

    if (ST_RAW < 0 || ST_RAW > 16'sh2000) begin : g_check
        $error("ST_RAW must be a small positive stimulus");
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] scale_axis(input logic signed [RAW_W-1:0] raw,
            input logic [15:0] gain, input logic [15:0] foff, input logic [15:0] uoff,
            input logic st_on, input logic [1:0] rng);
        logic signed [SUM_W-1:0] prod;
        logic signed [SUM_W-1:0] sum;
        logic signed [SUM_W-1:0] sh;
        logic [1:0] rsel;
        prod = SUM_W'(raw) * SUM_W'(GAIN_UNITY + $signed(gain[7:0]));
        sum = (prod >>> GAIN_SHIFT) + SUM_W'($signed(foff)) + SUM_W'($signed(uoff));
        sum = sum + (st_on ? SUM_W'(ST_RAW) : SUM_W'(0));
        rsel = (rng > RANGE_8G) ? RANGE_8G : rng;
        sh = sum >>> (BASE_SHIFT + int'(rsel));
        if (sh > SUM_W'(2047)) begin
            scale_axis = 12'h7ff;
        end else if (sh < -SUM_W'(2048)) begin
            scale_axis = 12'h800;
        end else begin
            scale_axis = sh[DATA_W-1:0];
        end
    endfunction

    // Upper byte is bits 11..4, lower byte holds bits 3..0 in its top nibble.
    function automatic logic [7:0] out_byte(input axis_out_t o, input logic [2:0] idx);
        logic [DATA_W-1:0] a;
        a = (idx < 3'h2) ? o.x : ((idx < 3'h4) ? o.y : o.z);
        out_byte = idx[0] ? {a[3:0], 4'h0} : a[11:4];
    endfunction

    function automatic logic [2:0] step_ptr(input logic [2:0] p, input logic fast);
        if (fast) begin
            step_ptr = (p >= PTR_LAST_MSB) ? PTR_RESET : {p[2:1], 1'b0} + 3'h2;
        end else begin
            step_ptr = (p >= PTR_LAST) ? PTR_RESET : p + 3'h1;
        end
    endfunction

    // ------------------------------------------------------------
    // Link domain: reset release, enable sync, sample handshake
    // ------------------------------------------------------------
    logic lrst_q1;
    logic lrst_q2;
    logic en_s1;
    logic en_s2;
    logic ack_s1;
    logic ack_s2;
    logic req_t;
    logic next_req_t;
    axis_raw_t hold;
    axis_raw_t next_hold;
    logic ack_t;

    always_ff @(posedge sense_clk or negedge rstn) begin
        if (!rstn) begin
            lrst_q1 <= 1'b0;
            lrst_q2 <= 1'b0;
        end else begin
            lrst_q1 <= 1'b1;
            lrst_q2 <= lrst_q1;
        end
    end

    always_comb begin
        next_req_t = req_t;
        next_hold = hold;
        // Sampling stops in standby; the holding word stays still until acknowledged.
        if (raw_valid && en_s2 && (req_t == ack_s2)) begin
            next_hold = raw_sample;
            next_req_t = ~req_t;
        end
    end

    always_ff @(posedge sense_clk or negedge lrst_q2) begin
        if (!lrst_q2) begin
            en_s1 <= 1'b0;
            en_s2 <= 1'b0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            req_t <= 1'b0;
            hold <= '0;
        end else begin
            en_s1 <= analog_en;
            en_s2 <= en_s1;
            ack_s1 <= ack_t;
            ack_s2 <= ack_s1;
            req_t <= next_req_t;
            hold <= next_hold;
        end
    end

    assign sampling_en = en_s2;

    // ------------------------------------------------------------
    // System domain state
    // ------------------------------------------------------------
    mode_t mode;
    mode_t next_mode;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic [15:0] trim [NVM_WORDS];
    logic [15:0] next_trim [NVM_WORDS];
    logic [7:0] uoff [OUT_REGS];
    logic [7:0] next_uoff [OUT_REGS];
    logic [2:0] issue_idx;
    logic [2:0] next_issue_idx;
    logic next_nvm_rd;
    logic [2:0] next_nvm_addr;
    logic cap_vld;
    logic [2:0] cap_idx;
    logic active;
    logic next_active;
    logic fast_read;
    logic next_fast_read;
    logic [1:0] range;
    logic [1:0] next_range;
    logic self_test;
    logic next_self_test;
    axis_out_t out_data;
    axis_out_t next_out_data;
    logic data_ready;
    logic next_data_ready;
    logic [2:0] burst_ptr;
    logic [2:0] next_burst_ptr;
    logic ack;
    logic [31:0] next_readdata;
    logic [1:0] sysmode;
    logic new_sample;
    logic done;
    logic clr_ready;

    assign new_sample = req_s2 ^ req_s3;
    assign done = (read | write) & ack;
    assign waitrequest = (read | write) & ~ack;
    assign ack_t = req_s3;
    assign sysmode = (mode == MODE_WAKE) ? SYSMODE_WAKE :
                     ((mode == MODE_SLEEP) ? SYSMODE_SLEEP : SYSMODE_STANDBY);
    assign clr_ready = done & read & ((address == OUT_BASE_OFS) ||
                       ((address == BURST_OFS) && (burst_ptr == PTR_RESET)));

    always_comb begin
        next_mode = mode;
        next_trim = trim;
        next_uoff = uoff;
        next_issue_idx = issue_idx;
        next_nvm_rd = 1'b0;
        next_nvm_addr = nvm_addr;
        next_active = active;
        next_fast_read = fast_read;
        next_range = range;
        next_self_test = self_test;
        next_out_data = out_data;
        next_data_ready = data_ready & ~clr_ready;
        next_burst_ptr = burst_ptr;
        next_readdata = readdata;

        // Trim is fetched before the block may leave the load state.
        if (mode == MODE_LOAD && issue_idx < 3'(NVM_WORDS)) begin
            next_nvm_rd = 1'b1;
            next_nvm_addr = issue_idx;
            next_issue_idx = issue_idx + 3'h1;
        end
        if (cap_vld) begin
            next_trim[cap_idx] = nvm_data;
        end

        case (mode)
            MODE_LOAD: begin
                if (issue_idx == 3'(NVM_WORDS) && !nvm_rd && !cap_vld) begin
                    next_mode = MODE_STANDBY;
                end
            end
            MODE_STANDBY: begin
                if (active) begin
                    next_mode = MODE_WAKE;
                    next_out_data = '0;
                    next_data_ready = 1'b0;
                    next_burst_ptr = PTR_RESET;
                end
            end
            MODE_WAKE: begin
                if (!active) begin
                    next_mode = MODE_STANDBY;
                end else if (sleep_req) begin
                    next_mode = MODE_SLEEP;
                end
            end
            MODE_SLEEP: begin
                if (!active) begin
                    next_mode = MODE_STANDBY;
                end else if (!sleep_req) begin
                    next_mode = MODE_WAKE;
                end
            end
            default: begin
                next_mode = MODE_LOAD;
            end
        endcase

        // A sample caught in the cycle its flag is read still sets the flag.
        if (new_sample && (mode == MODE_WAKE || mode == MODE_SLEEP)) begin
            next_out_data.x = scale_axis(hold.x, trim[0], trim[FAC_OFF_IDX],
                                         {uoff[0], uoff[1]}, self_test, range);
            next_out_data.y = scale_axis(hold.y, trim[1], trim[FAC_OFF_IDX + 3'h1],
                                         {uoff[2], uoff[3]}, self_test, range);
            next_out_data.z = scale_axis(hold.z, trim[2], trim[FAC_OFF_IDX + 3'h2],
                                         {uoff[4], uoff[5]}, self_test, range);
            next_data_ready = 1'b1;
        end

        // The read word is fixed in the first bus cycle and stands at completion.
        if (read && !ack) begin
            next_readdata = '0;
            if (address == STATUS_OFS) begin
                next_readdata[0] = data_ready;
                next_readdata[STATUS_MODE_LSB +: 2] = sysmode;
            end else if (address >= OUT_BASE_OFS && address < CTRL_OFS && address[1:0] == 2'h0) begin
                next_readdata[7:0] = out_byte(out_data, 3'((address - OUT_BASE_OFS) >> 2));
            end else if (address == CTRL_OFS) begin
                next_readdata[CTRL_ACTIVE_BIT] = active;
                next_readdata[CTRL_FREAD_BIT] = fast_read;
            end else if (address == CFG_OFS) begin
                next_readdata[1:0] = range;
                next_readdata[CFG_ST_BIT] = self_test;
            end else if (address >= UOFF_BASE_OFS && address < BURST_OFS && address[1:0] == 2'h0) begin
                next_readdata[7:0] = uoff[3'((address - UOFF_BASE_OFS) >> 2)];
            end else if (address == BURST_OFS) begin
                next_readdata[7:0] = out_byte(out_data, burst_ptr);
            end else if (address == PTR_OFS) begin
                next_readdata[2:0] = burst_ptr;
            end
        end

        if (done && read && address == BURST_OFS) begin
            next_burst_ptr = step_ptr(burst_ptr, fast_read);
        end

        if (done && write) begin
            if (address == CTRL_OFS) begin
                next_active = writedata[CTRL_ACTIVE_BIT];
                next_fast_read = writedata[CTRL_FREAD_BIT];
            end else if (address == CFG_OFS) begin
                next_range = writedata[1:0];
                next_self_test = writedata[CFG_ST_BIT];
            end else if (address >= UOFF_BASE_OFS && address < BURST_OFS && address[1:0] == 2'h0) begin
                next_uoff[3'((address - UOFF_BASE_OFS) >> 2)] = writedata[7:0];
            end else if (address == PTR_OFS) begin
                next_burst_ptr = (writedata[2:0] > PTR_LAST) ? PTR_RESET : writedata[2:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode <= MODE_LOAD;
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            trim <= '{default: 16'h0000};
            uoff <= '{default: 8'h00};
            issue_idx <= 3'h0;
            nvm_rd <= 1'b0;
            nvm_addr <= 3'h0;
            cap_vld <= 1'b0;
            cap_idx <= 3'h0;
            active <= 1'b0;
            fast_read <= 1'b0;
            range <= RANGE_2G;
            self_test <= 1'b0;
            out_data <= '0;
            data_ready <= 1'b0;
            burst_ptr <= PTR_RESET;
            ack <= 1'b0;
            readdata <= '0;
            analog_en <= 1'b0;
        end else begin
            mode <= next_mode;
            req_s1 <= req_t;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            trim <= next_trim;
            uoff <= next_uoff;
            issue_idx <= next_issue_idx;
            nvm_rd <= next_nvm_rd;
            nvm_addr <= next_nvm_addr;
            cap_vld <= nvm_rd;
            cap_idx <= nvm_addr;
            active <= next_active;
            fast_read <= next_fast_read;
            range <= next_range;
            self_test <= next_self_test;
            out_data <= next_out_data;
            data_ready <= next_data_ready;
            burst_ptr <= next_burst_ptr;
            ack <= (read | write) & ~ack;
            readdata <= next_readdata;
            analog_en <= (next_mode == MODE_WAKE) || (next_mode == MODE_SLEEP);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    a_standby_quiet: assert property ((mode == MODE_STANDBY) |-> !analog_en)
        else $error("analog enabled in standby");
    a_active_entry: assert property ((mode == MODE_STANDBY && active) |=> (mode == MODE_WAKE && analog_en))
        else $error("active bit did not start sampling");
    a_standby_retain: assert property ((mode == MODE_STANDBY && !active && !(done && write)) |=> ($stable(out_data) && $stable(range) && $stable(fast_read)))
        else $error("register changed in standby");
    a_entry_clear: assert property ((mode == MODE_STANDBY && active) |=> (out_data == '0 && !data_ready))
        else $error("output data not cleared on entry");
    a_sleep_active: assert property ((mode == MODE_SLEEP || mode == MODE_WAKE) |-> (active || $past(active)))
        else $error("sleep or wake outside active");
    a_msb_byte: assert property ((done && read && address == OUT_BASE_OFS) |-> readdata == {24'h0, $past(out_data.x[11:4])})
        else $error("upper byte not bits 11..4");
    a_fast_skip: assert property ((done && read && address == BURST_OFS && fast_read && burst_ptr == 3'h0) |=> burst_ptr == 3'h2)
        else $error("fast burst did not skip lower byte");
    a_slow_step: assert property ((done && read && address == BURST_OFS && !fast_read && burst_ptr == 3'h0) |=> burst_ptr == 3'h1)
        else $error("normal burst skipped a byte");
    a_trim_first: assert property ((mode == MODE_LOAD) |-> (!analog_en && !data_ready))
        else $error("measurement before trim loaded");
    a_bus_answer: assert property (((read || write) && waitrequest) |=> !waitrequest)
        else $error("bus answer not in one cycle");

    c_enter_wake: cover property (mode == MODE_STANDBY ##1 mode == MODE_WAKE);
    c_enter_sleep: cover property (mode == MODE_WAKE ##1 mode == MODE_SLEEP);
    c_fast_burst: cover property (done && read && address == BURST_OFS && fast_read);
    c_sample_seen: cover property (new_sample && mode == MODE_WAKE);

endmodule

/* File: sim/accel_front_model.sv */
/*
 * Behavioural far side of the readout block: the trim store and the sampling front end.
 * Assumes ref_clk for the trim store and a free-running sense_clk for the samples.
 */
module accel_front_model (
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic sense_clk,
    input wire logic rstn,
    // Trim store
    input wire logic nvm_rd,
    input wire logic [2:0] nvm_addr,
    output logic [15:0] nvm_data,
    input wire logic [95:0] trim,
    // Sample source
    input wire logic sampling_en,
    input wire accel_pkg::axis_raw_t target,
    output logic raw_valid,
    output accel_pkg::axis_raw_t raw_sample
);
    import accel_pkg::*;

    // ------------------------------------------------------------
    // Trim words answer one cycle after the strobe.
    // ------------------------------------------------------------
    // Between reads the word is inverted so a late capture cannot pass by luck.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            nvm_data <= 16'h0000;
        end else if (nvm_rd) begin
            nvm_data <= trim[nvm_addr * 16 +: 16];
        end else begin
            nvm_data <= ~nvm_data;
        end
    end

    // ------------------------------------------------------------
    // Signed samples only while the block lets the front end run.
    // ------------------------------------------------------------
    always @(posedge sense_clk or negedge rstn) begin
        if (!rstn) begin
            raw_valid <= 1'b0;
            raw_sample <= '0;
        end else begin
            raw_valid <= sampling_en;
            raw_sample <= sampling_en ? target : ~raw_sample;
        end
    end
endmodule

/* File: sim/tb.sv */
/*
 * Self-checking bench of the readout block: bus reads are noted in a queue and checked
 * by a watcher. Assumes the block answers every request in time; a watchdog ends a hang.
 */
module tb;
    import accel_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Signals and expectations
    // ------------------------------------------------------------
    localparam logic [95:0] TRIM = {16'h0000, 16'hffc0, 16'h0040, 16'h0000, 16'h00f0, 16'h0010};
    localparam logic signed [15:0] ST = 16'sh0400;
    typedef struct packed {logic [31:0] v; logic [31:0] m;} note_t;
    logic ref_clk = 1'b0, sense_clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0;
    logic sleep_req = 1'b0, raw_valid, sampling_en, analog_en, nvm_rd, waitrequest;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0, readdata, ev [6];
    logic [2:0] nvm_addr;
    logic [15:0] nvm_data;
    logic [31:0] seed = 32'd27380;
    axis_raw_t raw_sample, target = '0;
    note_t q [$];
    int errors = 0, comparisons = 0, rv [3], uo [3], st = 0, rng = 0;

    always #2 ref_clk = ~ref_clk;
    initial begin
        #13;
        forever #32 sense_clk = ~sense_clk;
    end

    accel_readout #(.ST_RAW(ST)) accel_readout_inst (.ref_clk(ref_clk), .rstn(rstn),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .sense_clk(sense_clk),
        .raw_sample(raw_sample), .raw_valid(raw_valid), .sampling_en(sampling_en),
        .analog_en(analog_en), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_data(nvm_data),
        .sleep_req(sleep_req));
    accel_front_model accel_front_model_inst (.ref_clk(ref_clk), .sense_clk(sense_clk),
        .rstn(rstn), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_data(nvm_data), .trim(TRIM),
        .sampling_en(sampling_en), .target(target), .raw_valid(raw_valid),
        .raw_sample(raw_sample));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [11:0] calc(int raw, int g, int fo, int u, int s, int r);
        int a;
        a = ((raw * (256 + g)) >>> 8) + fo + u + s;
        a = a >>> (2 + ((r > 2) ? 2 : r));
        if (a > 2047) a = 2047;
        if (a < -2048) a = -2048;
        return a[11:0];
    endfunction

    task automatic cmp_bus(input logic [31:0] got, input note_t n);
        comparisons++;
        if ((got & n.m) !== (n.v & n.m)) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got & n.m, n.v & n.m);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Read data are taken at the rising edge that samples waitrequest low.
    always @(posedge ref_clk) begin
        if (read === 1'b1 && waitrequest === 1'b0 && q.size() > 0) cmp_bus(readdata, q.pop_front());
    end

    task automatic bus_go(input logic [7:0] a, input logic [31:0] d, input logic wr);
        @(posedge ref_clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        q.push_back('{e, m});
        bus_go(a, 32'h0, 1'b0);
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        bus_go(a, d, 1'b1);
    endtask

    task automatic check_axes();
        logic [11:0] v;
        for (int i = 0; i < 3; i++) begin
            v = calc(rv[i], int'($signed(TRIM[i * 16 +: 8])), int'($signed(TRIM[(i + 3) * 16 +: 16])),
                uo[i], st ? int'(ST) : 0, rng);
            ev[2 * i] = {24'h0, v[11:4]};
            ev[2 * i + 1] = {24'h0, v[3:0], 4'h0};
            bus_rd(OUT_BASE_OFS + 8'(8 * i), ev[2 * i], 32'hff);
            bus_rd(OUT_BASE_OFS + 8'(8 * i + 4), ev[2 * i + 1], 32'hff);
        end
    endtask

    task automatic set_raw();
        for (int i = 0; i < 3; i++) rv[i] = int'($signed(xs())) >>> 18;
        target <= {16'(rv[0]), 16'(rv[1]), 16'(rv[2])};
    endtask

    task automatic report_and_stop();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (40) @(posedge ref_clk);
        chk_pin(analog_en, 1'b0);
        chk_pin(sampling_en, 1'b0);
        bus_rd(STATUS_OFS, 32'h0, 32'h6);
        bus_rd(8'h80, 32'h0, 32'hffffffff);
        bus_wr(CTRL_OFS, 32'h1);
        repeat (100) @(posedge ref_clk);
        chk_pin(analog_en, 1'b1);
        chk_pin(sampling_en, 1'b1);
        bus_rd(STATUS_OFS, 32'h2, 32'h6);
        sleep_req <= 1'b1;
        repeat (20) @(posedge ref_clk);
        bus_rd(STATUS_OFS, 32'h4, 32'h6);
        chk_pin(analog_en, 1'b1);
        sleep_req <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            st = k & 1;
            rng = k >> 1;
            bus_wr(CFG_OFS, 32'(st * 4 + rng));
            for (int i = 0; i < 3; i++) begin
                uo[i] = int'($signed(xs())) >>> 20;
                bus_wr(UOFF_BASE_OFS + 8'(8 * i), 32'(uo[i] >> 8) & 32'hff);
                bus_wr(UOFF_BASE_OFS + 8'(8 * i + 4), 32'(uo[i]) & 32'hff);
            end
            set_raw();
            repeat (300) @(posedge ref_clk);
            check_axes();
        end
        bus_wr(CTRL_OFS, 32'h3);
        bus_wr(PTR_OFS, 32'h0);
        for (int i = 0; i < 4; i++) bus_rd(BURST_OFS, ev[(2 * i) % 6], 32'hff);
        bus_wr(CTRL_OFS, 32'h1);
        bus_wr(PTR_OFS, 32'h0);
        for (int i = 0; i < 6; i++) bus_rd(BURST_OFS, ev[i], 32'hff);
        bus_wr(PTR_OFS, 32'h7);
        bus_rd(PTR_OFS, 32'h0, 32'h7);
        bus_wr(OUT_BASE_OFS, 32'hff);
        bus_wr(CTRL_OFS, 32'h0);
        repeat (100) @(posedge ref_clk);
        chk_pin(analog_en, 1'b0);
        chk_pin(sampling_en, 1'b0);
        set_raw();
        repeat (300) @(posedge ref_clk);
        for (int i = 0; i < 6; i++) bus_rd(OUT_BASE_OFS + 8'(4 * i), ev[i], 32'hff);
        bus_rd(CFG_OFS, 32'(st * 4 + rng), 32'h7);
        bus_rd(UOFF_BASE_OFS + 8'h14, 32'(uo[2]) & 32'hff, 32'hff);
        bus_wr(CTRL_OFS, 32'h1);
        bus_rd(OUT_BASE_OFS, 32'h0, 32'hff);
        bus_rd(STATUS_OFS, 32'h2, 32'h7);
        report_and_stop();
    end
endmodule
